/* rtl/irq_ctrl_pkg.sv */
// constants, register map and source order of the two-level interrupt controller
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package irq_ctrl_pkg;
   // ------------------------------------------------------------------------
   // register addresses and reset values
   // ------------------------------------------------------------------------
   localparam logic [7:0] IE_ADDR = 8'hA8;
   localparam logic [7:0] INTERRUPT_ENABLE_PRIORITY_SECONDARY_ADDR = 8'hA9;
   localparam logic [7:0] IP_ADDR = 8'hB8;
   localparam logic [7:0] IE_RST = 8'h00;
   localparam logic [7:0] IP_RST = 8'h00;
   localparam logic [7:0] INTERRUPT_ENABLE_PRIORITY_SECONDARY_RST = 8'hA0;
   localparam logic [7:0] IP_WMASK = 8'h7F;
   // ------------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------------
   localparam int GATE_BIT = 7;
   localparam int ADC_BIT = 6;
   localparam int T2_BIT = 5;
   localparam int UART_BIT = 4;
   localparam int T1_BIT = 3;
   localparam int EXT1_BIT = 2;
   localparam int T0_BIT = 1;
   localparam int EXT0_BIT = 0;
   localparam int TIC_EN_BIT = 2;
   localparam int PSM_EN_BIT = 1;
   localparam int SPI_EN_BIT = 0;
   localparam int TIC_PRIO_BIT = 6;
   localparam int PSM_PRIO_BIT = 5;
   localparam int SPI_PRIO_BIT = 4;
   localparam int INTERRUPT_ENABLE_PRIORITY_SECONDARY_RSVD_HI_BIT = 7;
   // ------------------------------------------------------------------------
   // sources in poll order, index 0 wins a tie
   // ------------------------------------------------------------------------
   localparam int NSRC = 11;
   localparam int SRC_PSM = 0;
   localparam int SRC_WDT = 1;
   localparam int SRC_EXT0 = 2;
   localparam int SRC_ADC = 3;
   localparam int SRC_T0 = 4;
   localparam int SRC_EXT1 = 5;
   localparam int SRC_T1 = 6;
   localparam int SRC_SPI = 7;
   localparam int SRC_UART = 8;
   localparam int SRC_T2 = 9;
   localparam int SRC_TIC = 10;
   // entry k is the vector of source index k
   localparam logic [NSRC-1:0][15:0] VEC_TABLE = {
      16'h0053, 16'h002B, 16'h0023, 16'h003B, 16'h001B, 16'h0013,
      16'h000B, 16'h0033, 16'h0003, 16'h005B, 16'h0043};
   // nesting of routines in service
   typedef enum logic [1:0] {
      NEST_IDLE = 2'b00,
      NEST_LOW = 2'b01,
      NEST_HIGH = 2'b10,
      NEST_BOTH = 2'b11
   } nest_type;
endpackage : irq_ctrl_pkg

/* rtl/irq_ctrl.sv */
// two-level prioritised interrupt controller with sfr access and vector output
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl
   import irq_ctrl_pkg::*;
#(
   parameter int WDT_TW = 4
) (
   input wire logic I_CLK, // core clock
   input wire logic I_RST, // sync reset, high
   input wire logic I_CE, // clock enable, low freezes all
   input wire logic [7:0] I_SFR_ADDR, // sfr byte address
   input wire logic [7:0] I_SFR_WDATA, // sfr write data
   input wire logic I_SFR_WR, // sfr byte write strobe
   input wire logic I_SFR_RD, // sfr byte read strobe
   output logic [7:0] O_SFR_RDATA, // read data, next cycle
   input wire logic [7:0] I_BIT_ADDR, // bit address
   input wire logic I_BIT_DATA, // bit write value
   input wire logic I_BIT_WR, // bit write strobe
   input wire logic I_EXT0_FLAG, // external 0 flag
   input wire logic I_EXT1_FLAG, // external 1 flag
   input wire logic I_TIMER0_OVERFLOW_FLAG, // timer 0 flag
   input wire logic I_TIMER1_OVERFLOW_FLAG, // timer 1 flag
   input wire logic I_TIMER2_OVERFLOW_FLAG, // timer 2 overflow
   input wire logic I_TIMER2_EXTERNAL_FLAG, // timer 2 external
   input wire logic [1:0] I_ADC_DONE_FLAGS, // adc ready flags
   input wire logic I_UART_RX_FLAG, // uart receive
   input wire logic I_UART_TX_FLAG, // uart transmit
   input wire logic I_SPI_DONE_FLAG, // spi done
   input wire logic I_SUPPLY_MONITOR_FLAG, // supply monitor
   input wire logic I_INTERVAL_COUNTER_FLAG, // interval counter
   input wire logic I_WATCHDOG_TIMEOUT_FLAG, // watchdog timed out
   input wire logic I_WATCHDOG_IRQ_MODE, // watchdog in irq mode
   input wire logic [WDT_TW-1:0] I_WATCHDOG_TIMEOUT, // timeout setting
   input wire logic I_IRQ_ACK, // core takes request, pulse
   input wire logic I_RETI, // core returns from routine, pulse
   output logic O_IRQ_REQ, // request to core, level
   output logic [15:0] O_IRQ_VECTOR, // vector of request
   output logic O_IRQ_LEVEL, // level of request, 1 high
   output logic [1:0] O_NEST // routines in service
);
   // ------------------------------------------------------------------------
   // registers
   // ------------------------------------------------------------------------
   logic [7:0] ie_r;
   logic [7:0] ip_r;
   logic [7:0] interrupt_enable_priority_secondary_r;
   logic [7:0] rdata_r;
   logic req_r;
   logic [15:0] vec_r;
   logic lvl_r;
   nest_type nest_r;
   nest_type nest_nxt;
   logic [NSRC-1:0] flag;
   logic [NSRC-1:0] en;
   logic [NSRC-1:0] hi;
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] pend_hi;
   logic [NSRC-1:0] pend_lo;
   logic wdt_pend;
   logic take;
   logic ins_hi;
   logic ins_lo;
   logic allow_lo;
   logic sel_ok;
   logic sel_lvl;
   logic [3:0] sel_idx;

   assign ins_hi = nest_r[1];
   assign ins_lo = nest_r[0];
   assign take = I_CE && I_IRQ_ACK && req_r;

   // ------------------------------------------------------------------------
   // request gathering
   // ------------------------------------------------------------------------
   always_comb begin
      flag = '0;
      flag[SRC_PSM] = I_SUPPLY_MONITOR_FLAG;
      flag[SRC_WDT] = I_WATCHDOG_TIMEOUT_FLAG;
      flag[SRC_EXT0] = I_EXT0_FLAG;
      flag[SRC_ADC] = |I_ADC_DONE_FLAGS;
      flag[SRC_T0] = I_TIMER0_OVERFLOW_FLAG;
      flag[SRC_EXT1] = I_EXT1_FLAG;
      flag[SRC_T1] = I_TIMER1_OVERFLOW_FLAG;
      flag[SRC_SPI] = I_SPI_DONE_FLAG;
      flag[SRC_UART] = I_UART_RX_FLAG || I_UART_TX_FLAG;
      flag[SRC_T2] = I_TIMER2_OVERFLOW_FLAG || I_TIMER2_EXTERNAL_FLAG;
      flag[SRC_TIC] = I_INTERVAL_COUNTER_FLAG;
   end

   always_comb begin
      en = '0;
      hi = '0;
      en[SRC_EXT0] = ie_r[EXT0_BIT];
      en[SRC_T0] = ie_r[T0_BIT];
      en[SRC_EXT1] = ie_r[EXT1_BIT];
      en[SRC_T1] = ie_r[T1_BIT];
      en[SRC_UART] = ie_r[UART_BIT];
      en[SRC_T2] = ie_r[T2_BIT];
      en[SRC_ADC] = ie_r[ADC_BIT];
      en[SRC_TIC] = interrupt_enable_priority_secondary_r[TIC_EN_BIT];
      en[SRC_PSM] = interrupt_enable_priority_secondary_r[PSM_EN_BIT];
      en[SRC_SPI] = interrupt_enable_priority_secondary_r[SPI_EN_BIT];
      hi[SRC_EXT0] = ip_r[EXT0_BIT];
      hi[SRC_T0] = ip_r[T0_BIT];
      hi[SRC_EXT1] = ip_r[EXT1_BIT];
      hi[SRC_T1] = ip_r[T1_BIT];
      hi[SRC_UART] = ip_r[UART_BIT];
      hi[SRC_T2] = ip_r[T2_BIT];
      hi[SRC_ADC] = ip_r[ADC_BIT];
      hi[SRC_TIC] = interrupt_enable_priority_secondary_r[TIC_PRIO_BIT];
      hi[SRC_PSM] = interrupt_enable_priority_secondary_r[PSM_PRIO_BIT];
      hi[SRC_SPI] = interrupt_enable_priority_secondary_r[SPI_PRIO_BIT];
      hi[SRC_WDT] = 1'b1;
   end

   // watchdog bypasses the gate so a hung masked system still gets logged
   assign wdt_pend = I_WATCHDOG_TIMEOUT_FLAG && I_WATCHDOG_IRQ_MODE
                     && (I_WATCHDOG_TIMEOUT != '0);

   always_comb begin
      pend = flag & en & {NSRC{ie_r[GATE_BIT]}};
      pend[SRC_WDT] = wdt_pend;
   end

   // a level already in service blocks itself and anything below
   assign allow_lo = !ins_hi && !ins_lo;
   assign pend_hi = ins_hi ? '0 : (pend & hi);
   assign pend_lo = allow_lo ? (pend & ~hi) : '0;

   // ------------------------------------------------------------------------
   // arbitration: level first, then poll order
   // ------------------------------------------------------------------------
   always_comb begin
      sel_ok = 1'b0;
      sel_lvl = 1'b0;
      sel_idx = 4'h0;
      for (int k = NSRC - 1; k >= 0; k--) begin
         if (pend_lo[k]) begin
            sel_ok = 1'b1;
            sel_idx = 4'(k);
         end
      end
      for (int k = NSRC - 1; k >= 0; k--) begin
         if (pend_hi[k]) begin
            sel_ok = 1'b1;
            sel_lvl = 1'b1;
            sel_idx = 4'(k);
         end
      end
   end

   // request is re-evaluated each enabled cycle; dropped for the take cycle
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         req_r <= 1'b0;
         vec_r <= 16'h0000;
         lvl_r <= 1'b0;
      end else if (I_CE) begin
         req_r <= sel_ok && !take;
         vec_r <= VEC_TABLE[sel_idx];
         lvl_r <= sel_lvl;
      end
   end

   // ------------------------------------------------------------------------
   // nesting of routines in service
   // ------------------------------------------------------------------------
   always_comb begin
      nest_nxt = nest_r;
      if (I_RETI) begin
         case (nest_r)
            NEST_BOTH: nest_nxt = NEST_LOW;
            NEST_HIGH: nest_nxt = NEST_IDLE;
            NEST_LOW: nest_nxt = NEST_IDLE;
            default: nest_nxt = NEST_IDLE;
         endcase
      end
      // a take in the same cycle as a return is kept, never lost
      if (take) begin
         case (nest_nxt)
            NEST_IDLE: nest_nxt = lvl_r ? NEST_HIGH : NEST_LOW;
            NEST_LOW: nest_nxt = lvl_r ? NEST_BOTH : NEST_LOW;
            NEST_HIGH: nest_nxt = NEST_HIGH;
            default: nest_nxt = NEST_BOTH;
         endcase
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         nest_r <= NEST_IDLE;
      end else if (I_CE) begin
         nest_r <= nest_nxt;
      end
   end

   // ------------------------------------------------------------------------
   // sfr writes; byte and bit paths, byte write wins on a clash
   // ------------------------------------------------------------------------
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         ie_r <= IE_RST;
         ip_r <= IP_RST;
      end else if (I_CE) begin
         if (I_BIT_WR && I_BIT_ADDR[7:3] == IE_ADDR[7:3]) begin
            ie_r[I_BIT_ADDR[2:0]] <= I_BIT_DATA;
         end
         if (I_BIT_WR && I_BIT_ADDR[7:3] == IP_ADDR[7:3]
             && I_BIT_ADDR[2:0] != 3'h7) begin
            ip_r[I_BIT_ADDR[2:0]] <= I_BIT_DATA;
         end
         if (I_SFR_WR && I_SFR_ADDR == IE_ADDR) begin
            ie_r <= I_SFR_WDATA;
         end
         if (I_SFR_WR && I_SFR_ADDR == IP_ADDR) begin
            ip_r <= I_SFR_WDATA & IP_WMASK;
         end
      end
   end

   // byte access only; top bit is fixed at its reset value
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         interrupt_enable_priority_secondary_r <= INTERRUPT_ENABLE_PRIORITY_SECONDARY_RST;
      end else if (I_CE && I_SFR_WR && I_SFR_ADDR == INTERRUPT_ENABLE_PRIORITY_SECONDARY_ADDR) begin
         interrupt_enable_priority_secondary_r <= {INTERRUPT_ENABLE_PRIORITY_SECONDARY_RST[INTERRUPT_ENABLE_PRIORITY_SECONDARY_RSVD_HI_BIT], I_SFR_WDATA[6:0]};
      end
   end

   // unmapped addresses read zero
   always_ff @(posedge I_CLK) begin
      if (I_RST) begin
         rdata_r <= 8'h00;
      end else if (I_CE && I_SFR_RD) begin
         case (I_SFR_ADDR)
            IE_ADDR: rdata_r <= ie_r;
            IP_ADDR: rdata_r <= ip_r;
            INTERRUPT_ENABLE_PRIORITY_SECONDARY_ADDR: rdata_r <= interrupt_enable_priority_secondary_r;
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   assign O_SFR_RDATA = rdata_r;
   assign O_IRQ_REQ = req_r;
   assign O_IRQ_VECTOR = vec_r;
   assign O_IRQ_LEVEL = lvl_r;
   assign O_NEST = nest_r;

   // ------------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);

   sequence s_take;
      take;
   endsequence

   sequence s_serviced;
      !req_r && (nest_r != NEST_IDLE);
   endsequence

   reset_vals_a: assert property (
      disable iff (1'b0) I_RST |=> ie_r == IE_RST && ip_r == IP_RST && interrupt_enable_priority_secondary_r == INTERRUPT_ENABLE_PRIORITY_SECONDARY_RST)
      else $error("reset values wrong");

   gate_block_a: assert property (
      I_CE && !ie_r[GATE_BIT] && !wdt_pend |=> !req_r)
      else $error("request while gate closed");

   no_pend_a: assert property (
      I_CE && pend == '0 |=> !req_r)
      else $error("request without pending source");

   wdt_serve_a: assert property (
      I_CE && !take && wdt_pend && !ins_hi && !(pend[SRC_PSM] && hi[SRC_PSM])
      |=> req_r && lvl_r && vec_r == VEC_TABLE[SRC_WDT])
      else $error("watchdog not requested at high level");

   wdt_cause_a: assert property (
      $past(I_CE) && req_r && vec_r == VEC_TABLE[SRC_WDT] |-> $past(wdt_pend))
      else $error("watchdog vector without valid timeout");

   hi_first_a: assert property (
      I_CE && !take && pend_hi != '0 |=> req_r && lvl_r)
      else $error("high level not served first");

   same_level_a: assert property (
      req_r |-> !ins_hi && (lvl_r || !ins_lo))
      else $error("same level preemption");

   take_seq_a: assert property (
      s_take |=> s_serviced)
      else $error("take did not enter service");

   preempt_a: assert property (
      take && lvl_r && nest_r == NEST_LOW && !I_RETI |=> nest_r == NEST_BOTH)
      else $error("high did not nest over low");

   reti_pop_a: assert property (
      I_CE && I_RETI && !take && nest_r == NEST_BOTH |=> nest_r == NEST_LOW ##1 ins_lo)
      else $error("return did not release high level");

   // ------------------------------------------------------------------------
   // register and freeze checks, then low blocking, tie and return checks
   // ------------------------------------------------------------------------
   ce_freeze_a: assert property (
      !I_CE |=> $stable(nest_r) && $stable(req_r) && $stable(ie_r) && $stable(interrupt_enable_priority_secondary_r))
      else $error("state moved while clock enable low");

   ip_rsvd_a: assert property (
      ip_r[7] == 1'b0)
      else $error("reserved priority bit set");

   interrupt_enable_priority_secondary_top_a: assert property (
      interrupt_enable_priority_secondary_r[INTERRUPT_ENABLE_PRIORITY_SECONDARY_RSVD_HI_BIT] == 1'b1)
      else $error("secondary top bit lost");

   interrupt_enable_priority_secondary_write_a: assert property (
      I_CE && I_SFR_WR && I_SFR_ADDR == INTERRUPT_ENABLE_PRIORITY_SECONDARY_ADDR |=> interrupt_enable_priority_secondary_r[6:0] == $past(I_SFR_WDATA[6:0]))
      else $error("secondary write did not land");

   ie_write_a: assert property (
      I_CE && I_SFR_WR && I_SFR_ADDR == IE_ADDR |=> ie_r == $past(I_SFR_WDATA))
      else $error("enable write did not land");

   lo_block_a: assert property (
      I_CE && ins_lo && pend_hi == '0 |=> !req_r)
      else $error("low request during low service");

   psm_first_a: assert property (
      I_CE && !take && pend[SRC_PSM] && hi[SRC_PSM] && !ins_hi |=> req_r && vec_r == VEC_TABLE[SRC_PSM])
      else $error("supply monitor lost high tie");

   reti_low_a: assert property (
      I_CE && I_RETI && !take && nest_r == NEST_LOW |=> nest_r == NEST_IDLE)
      else $error("return did not release low level");

endmodule : irq_ctrl
`default_nettype wire

/* test/core_seq_model.sv */
// core-side sequencer model: accepts requests on command and returns from routines
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
   input wire logic i_clk, // core clock
   input wire logic i_rst, // sync reset, high
   input wire logic i_req, // request from controller
   input wire logic [15:0] i_vector, // vector from controller
   input wire logic i_take, // accept the next request
   input wire logic [1:0] i_wait, // stall cycles before ack
   input wire logic i_ret, // leave the current routine
   output logic o_ack, // ack pulse
   output logic o_reti, // return pulse
   output logic o_taken, // ack met a request
   output logic [15:0] o_pc // vector loaded at ack
);
   logic [1:0] wait_r;
   initial begin
      o_ack = 1'b0;
      o_reti = 1'b0;
      o_taken = 1'b0;
      wait_r = 2'h0;
   end
   // drive after the falling edge; a slow core stalls up to three cycles
   always @(negedge i_clk) begin
      if (i_rst || o_ack || !(i_take && i_req)) begin
         o_ack <= 1'b0;
         wait_r <= 2'h0;
      end else if (wait_r >= i_wait) begin
         o_ack <= 1'b1;
      end else begin
         wait_r <= wait_r + 2'h1;
      end
      o_reti <= i_ret && !i_rst;
   end
   // the pushed pc is abstract; only the loaded vector is kept
   always @(posedge i_clk) begin
      o_taken <= o_ack && i_req;
      if (o_ack && i_req) begin
         o_pc <= i_vector;
      end
   end
endmodule : core_seq_model
`default_nettype wire

/* test/tb_irq_ctrl.sv */
// self-checking bench of the two-level interrupt controller against a queue model
`timescale 1ns/1ps
`default_nettype none
module tb_irq_ctrl
   import irq_ctrl_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bwr = 1'b0, bdat = 1'b0;
   logic [7:0] addr = 8'h00, wdat = 8'h00, baddr = 8'h00, rdata;
   logic [12:0] fl = 13'h0000;
   logic wf = 1'b0, wm = 1'b0, take = 1'b0, ret = 1'b0, ce = 1'b1;
   logic req, lvl, ack, reti, taken;
   logic [3:0] wt = 4'h0;
   logic [1:0] stall = 2'h0, nest;
   logic [15:0] vec, pc;
   logic [7:0] ie = 8'h00, ip = 8'h00, e2 = 8'hA0;
   logic [31:0] rs = 32'hD4E8;
   logic [15:0] vt [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
      16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};
   int q[$];
   int fail_count = 0, comparisons = 0;
   initial begin
      forever #2.5 clk = ~clk;
   end
   irq_ctrl #(.WDT_TW(4)) u_irq_ctrl (.I_CLK(clk), .I_RST(rst), .I_CE(ce),
      .I_SFR_ADDR(addr), .I_SFR_WDATA(wdat), .I_SFR_WR(wr), .I_SFR_RD(rd),
      .O_SFR_RDATA(rdata), .I_BIT_ADDR(baddr), .I_BIT_DATA(bdat), .I_BIT_WR(bwr),
      .I_EXT0_FLAG(fl[0]), .I_EXT1_FLAG(fl[1]), .I_TIMER0_OVERFLOW_FLAG(fl[2]),
      .I_TIMER1_OVERFLOW_FLAG(fl[3]), .I_TIMER2_OVERFLOW_FLAG(fl[4]),
      .I_TIMER2_EXTERNAL_FLAG(fl[5]), .I_ADC_DONE_FLAGS(fl[7:6]), .I_UART_RX_FLAG(fl[8]),
      .I_UART_TX_FLAG(fl[9]), .I_SPI_DONE_FLAG(fl[10]), .I_SUPPLY_MONITOR_FLAG(fl[11]),
      .I_INTERVAL_COUNTER_FLAG(fl[12]), .I_WATCHDOG_TIMEOUT_FLAG(wf),
      .I_WATCHDOG_IRQ_MODE(wm), .I_WATCHDOG_TIMEOUT(wt), .I_IRQ_ACK(ack), .I_RETI(reti),
      .O_IRQ_REQ(req), .O_IRQ_VECTOR(vec), .O_IRQ_LEVEL(lvl), .O_NEST(nest));
   core_seq_model u_core_seq_model (.i_clk(clk), .i_rst(rst), .i_req(req), .i_vector(vec),
      .i_take(take), .i_wait(stall), .i_ret(ret), .o_ack(ack), .o_reti(reti),
      .o_taken(taken), .o_pc(pc));
   // ------------------------------------------------------------------------
   // reference model
   // ------------------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [1:0] nest_m();
      logic [1:0] n;
      n = 2'h0;
      foreach (q[i]) n[q[i]] = 1'b1;
      return n;
   endfunction : nest_m
   function automatic logic [17:0] model();
      logic [10:0] pf, en, hi;
      logic [1:0] n;
      n = nest_m();
      pf = {fl[12], fl[4] | fl[5], fl[8] | fl[9], fl[10], fl[3], fl[1], fl[2],
         fl[6] | fl[7], fl[0], (wf && wm && wt != 4'h0), fl[11]};
      en = {e2[2], ie[5], ie[4], e2[0], ie[3], ie[2], ie[1], ie[6], ie[0], 1'b1, e2[1]}
         & ({11{ie[7]}} | 11'h002);
      hi = {e2[6], ip[5], ip[4], e2[4], ip[3], ip[2], ip[1], ip[6], ip[0], 1'b1, e2[5]};
      for (int lv = 1; lv >= 0; lv--) begin
         if (n[1] || (lv == 0 && n[0])) continue;
         for (int k = 0; k < 11; k++) begin
            if (pf[k] && en[k] && hi[k] == lv) return {1'b1, lv[0], vt[k]};
         end
      end
      return 18'h00000;
   endfunction : model
   // ------------------------------------------------------------------------
   // drivers and comparisons
   // ------------------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr <= a;
      wdat <= d;
      wr <= 1'b1;
      @(negedge clk);
      wr <= 1'b0;
   endtask : sfr_wr
   task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      addr <= a;
      rd <= 1'b1;
      @(negedge clk);
      rd <= 1'b0;
      chk(rdata, exp);
   endtask : sfr_rd
   task automatic bit_wr(input logic [7:0] a, input logic d);
      @(negedge clk);
      baddr <= a;
      bdat <= d;
      bwr <= 1'b1;
      @(negedge clk);
      bwr <= 1'b0;
   endtask : bit_wr
   task automatic settle();
      logic [17:0] m;
      repeat (2) @(negedge clk);
      m = model();
      chk(req, m[17]);
      if (m[17]) begin
         chk(vec, m[15:0]);
         chk(lvl, m[16]);
      end
      chk(nest, nest_m());
   endtask : settle
   task automatic take_one();
      logic [17:0] m;
      m = model();
      if (m[17]) begin
         @(negedge clk);
         take <= 1'b1;
         for (int i = 0; i < 20 && taken !== 1'b1; i++) @(negedge clk);
         take <= 1'b0;
         if (taken !== 1'b1) begin
            fail_count++;
            results();
         end else begin
            q.push_back(m[16]);
            chk(pc, m[15:0]);
         end
      end
   endtask : take_one
   task automatic ret_one();
      @(negedge clk);
      ret <= 1'b1;
      @(negedge clk);
      ret <= 1'b0;
      @(posedge clk);
      void'(q.pop_back());
   endtask : ret_one
   // ------------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------------
   initial begin
      repeat (4) @(negedge clk);
      rst <= 1'b0;
      sfr_rd(IE_ADDR, 8'h00);
      sfr_rd(IP_ADDR, 8'h00);
      sfr_rd(INTERRUPT_ENABLE_PRIORITY_SECONDARY_ADDR, 8'hA0);
      sfr_rd(8'hA7, 8'h00);
      bit_wr(8'hAF, 1'b1);
      bit_wr(8'hA8, 1'b1);
      bit_wr(8'hA9, 1'b1);
      bit_wr(8'hB9, 1'b1);
      bit_wr(8'hBF, 1'b1);
      ie = 8'h83;
      ip = 8'h02;
      sfr_rd(IE_ADDR, 8'h83);
      sfr_rd(IP_ADDR, 8'h02);
      fl <= 13'h0001;
      settle();
      take_one();
      fl <= 13'h0005;
      settle();
      take_one();
      settle();
      ret_one();
      settle();
      ret_one();
      sfr_wr(IE_ADDR, 8'h00);
      ie = 8'h00;
      fl <= 13'h1FFF;
      wf <= 1'b1;
      wm <= 1'b1;
      settle();
      wt <= 4'h1;
      settle();
      take_one();
      ret_one();
      for (int it = 0; it < 60; it++) begin
         rs = lfsr(rs);
         ie = rs[7:0];
         ip = rs[15:8] & 8'h7F;
         e2 = rs[23:16] & 8'hF7 | 8'h80;
         sfr_wr(IE_ADDR, rs[7:0]);
         sfr_wr(IP_ADDR, rs[15:8]);
         sfr_wr(INTERRUPT_ENABLE_PRIORITY_SECONDARY_ADDR, rs[23:16] & 8'hF7);
         sfr_rd(IE_ADDR, ie);
         sfr_rd(IP_ADDR, ip);
         sfr_rd(INTERRUPT_ENABLE_PRIORITY_SECONDARY_ADDR, e2);
         rs = lfsr(rs);
         fl <= rs[12:0];
         wt <= rs[16:13];
         wf <= rs[17];
         wm <= rs[18];
         stall <= rs[20:19];
         settle();
         take_one();
         settle();
         take_one();
         settle();
         while (q.size() > 0) begin
            ret_one();
            settle();
         end
      end
      // a write while the enable is low must not land
      @(negedge clk);
      ce <= 1'b0;
      sfr_wr(IE_ADDR, 8'hFF);
      @(negedge clk);
      ce <= 1'b1;
      sfr_rd(IE_ADDR, ie);
      @(negedge clk);
      rst <= 1'b1;
      @(negedge clk);
      rst <= 1'b0;
      ie = 8'h00;
      ip = 8'h00;
      e2 = 8'hA0;
      sfr_rd(INTERRUPT_ENABLE_PRIORITY_SECONDARY_ADDR, 8'hA0);
      settle();
      results();
   end
endmodule : tb_irq_ctrl
`default_nettype wire
